// File: preload_observe_consts.svh
// Constants for the macrocell preload/observe test block
`ifndef PRELOAD_OBSERVE_CONSTS_SVH
`define PRELOAD_OBSERVE_CONSTS_SVH

// Power-up reset time, longest, in microseconds
`define PR_TIME_US 10
// System clock period in nanoseconds
`define CLK_PERIOD_NS 10
`define NS_PER_US 1000

// Bank select: output macrocells or buried macrocells
`define BANK_OUT 1'b0
`define BANK_BUR 1'b1

// Reset values
`define POR_BUSY_RST 1'b1
`define PIN_OE_N_RST 1'b1
`define PIN_O_RST 1'b0

`endif

// File: preload_observe_pkg.sv
// Types shared by the macrocell preload/observe test block
`default_nettype none

package preload_observe_pkg;

   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_PRELOAD,
      MODE_OBSERVE
   } test_mode_type;

   // Per-cell configuration as programmed into the device
   typedef struct packed {
      logic comb;     // Output is combinatorial, not registered
      logic pol;      // Invert at the pin
      logic oe;       // Programmed output enable
   } cell_cfg_type;

endpackage : preload_observe_pkg

`default_nettype wire

// File: pin_stage.sv
// Pin output stage: functional drive, preload release and observe override
`default_nettype none
`include "preload_observe_consts.svh"

module pin_stage #(
   parameter int N_IO = 8
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire preload_observe_pkg::test_mode_type i_mode,
   input wire logic i_bank,
   input wire preload_observe_pkg::cell_cfg_type [N_IO-1:0] i_cfg,
   input wire logic [N_IO-1:0] i_d_out,
   input wire logic [N_IO-1:0] i_q_out,
   input wire logic [N_IO-1:0] i_q_bur,
   output logic [N_IO-1:0] o_pin_o,
   output logic [N_IO-1:0] o_pin_oe_n
);
   import preload_observe_pkg::*;

   typedef struct packed {
      logic [N_IO-1:0] pin_o;
      logic [N_IO-1:0] oe_n;
   } state_type;

   state_type s_r;
   state_type s_nxt;
   logic [N_IO-1:0] normal_val;
   logic [N_IO-1:0] observe_val;
   logic [N_IO-1:0] comb_mask;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < N_IO; i++) begin
         comb_mask[i] = i_cfg[i].comb;
         // A combinatorial output recomputes from live terms, so it is
         // correct again on the first clock edge in normal mode
         normal_val[i] = (i_cfg[i].comb ? i_d_out[i] : i_q_out[i]) ^ i_cfg[i].pol;
      end
      observe_val = (i_bank == `BANK_BUR) ? i_q_bur : i_q_out;
      s_nxt = s_r;
      unique case (i_mode)
         MODE_PRELOAD: begin
            // Pins become inputs so the tester can present the load value
            s_nxt.oe_n = {N_IO{1'b1}};
            s_nxt.pin_o = '0;
         end
         MODE_OBSERVE: begin
            // Programmed enable is overridden; combinatorial terms are
            // dropped and every cell shows its register
            s_nxt.oe_n = '0;
            s_nxt.pin_o = observe_val;
         end
         default: begin
            s_nxt.oe_n = '0;
            for (int i = 0; i < N_IO; i++) begin
               s_nxt.oe_n[i] = ~i_cfg[i].oe;
            end
            s_nxt.pin_o = normal_val;
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         s_r.pin_o <= {N_IO{`PIN_O_RST}};
         s_r.oe_n <= {N_IO{`PIN_OE_N_RST}};
      end else if (i_ce) begin
         s_r <= s_nxt;
      end
   end

   assign o_pin_o = s_r.pin_o;
   assign o_pin_oe_n = s_r.oe_n;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_obs_drive;
      @(posedge i_clock) disable iff (i_rst)
      (i_ce && i_mode == MODE_OBSERVE) |=>
         (o_pin_oe_n == '0) && (o_pin_o == $past(observe_val));
   endproperty
   a_obs_drive: assert property (p_obs_drive)
      else $error("observe did not drive register contents");

   property p_obs_no_comb;
      @(posedge i_clock) disable iff (i_rst)
      (i_ce && i_mode == MODE_OBSERVE && (i_d_out & comb_mask) != '0
         && i_bank == `BANK_OUT && (i_q_out & comb_mask) == '0) |=>
         ((o_pin_o & $past(comb_mask)) == '0);
   endproperty
   a_obs_no_comb: assert property (p_obs_no_comb)
      else $error("combinatorial data leaked during observe");

   property p_preload_release;
      @(posedge i_clock) disable iff (i_rst)
      (i_ce && i_mode == MODE_PRELOAD) |=> (o_pin_oe_n == {N_IO{1'b1}});
   endproperty
   a_preload_release: assert property (p_preload_release)
      else $error("pins still driven during preload");

   property p_comb_restore;
      @(posedge i_clock) disable iff (i_rst)
      (i_ce && i_mode == MODE_NORMAL && $past(i_mode) != MODE_NORMAL) |=>
         (o_pin_o == $past(normal_val));
   endproperty
   a_comb_restore: assert property (p_comb_restore)
      else $error("output not restored after test mode");

endmodule : pin_stage

`default_nettype wire

// File: macrocell_test_array.sv
// Macrocell register array with power-up reset, preload and observe
`default_nettype none
`include "preload_observe_consts.svh"

module macrocell_test_array #(
   parameter int N_IO = 8,
   parameter int AR_CELL = 0,
   parameter int AP_CELL = 1
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire preload_observe_pkg::test_mode_type i_mode,
   input wire logic i_bank,
   input wire preload_observe_pkg::cell_cfg_type [N_IO-1:0] i_cfg,
   input wire logic [N_IO-1:0] i_d_out,
   input wire logic [N_IO-1:0] i_d_bur,
   input wire logic i_ar_en,
   input wire logic i_ap_en,
   input wire logic [N_IO-1:0] i_pin_i,
   output logic [N_IO-1:0] o_pin_o,
   output logic [N_IO-1:0] o_pin_oe_n,
   output logic o_por_busy
);
   import preload_observe_pkg::*;

   // Power-up reset window in cycles, a longest time so rounded down
   localparam int POR_CYCLES = (`PR_TIME_US * `NS_PER_US) / `CLK_PERIOD_NS;
   localparam int CNT_W = $clog2(POR_CYCLES + 1);

   typedef struct packed {
      logic [N_IO-1:0] q_out;
      logic [N_IO-1:0] q_bur;
      logic [CNT_W-1:0] por_cnt;
      logic por_busy;
   } state_type;

   state_type s_r;
   state_type s_nxt;
   logic [2*N_IO-1:0] all_q;
   logic ar_hit;
   logic ap_hit;
   logic [N_IO-1:0] comb_mask;

   function automatic logic [N_IO-1:0] cfg_comb(
      input cell_cfg_type [N_IO-1:0] cfg
   );
      logic [N_IO-1:0] m;
      m = '0;
      for (int i = 0; i < N_IO; i++) begin
         m[i] = cfg[i].comb;
      end
      return m;
   endfunction : cfg_comb

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      comb_mask = cfg_comb(i_cfg);
      all_q = {s_r.q_bur, s_r.q_out};
      // Reset and preset lines are fed by register contents, so a
      // preloaded value can fire them on the following edge
      ar_hit = i_ar_en && all_q[AR_CELL];
      ap_hit = i_ap_en && all_q[AP_CELL];
      s_nxt = s_r;
      if (s_r.por_busy) begin
         s_nxt.q_out = '0;
         s_nxt.q_bur = '0;
         if (s_r.por_cnt == CNT_W'(POR_CYCLES - 1)) begin
            s_nxt.por_busy = 1'b0;
         end else begin
            s_nxt.por_cnt = s_r.por_cnt + 1'b1;
         end
      end else begin
         unique case (i_mode)
            MODE_PRELOAD: begin
               if (i_bank == `BANK_BUR) begin
                  s_nxt.q_bur = i_pin_i;
               end else begin
                  s_nxt.q_out = i_pin_i;
               end
            end
            MODE_OBSERVE: begin
               // Registers hold so that what is seen is what was stored
               s_nxt.q_out = s_r.q_out;
            end
            default: begin
               // Combinatorial cells do not use their register
               s_nxt.q_out = i_d_out & ~comb_mask;
               s_nxt.q_bur = i_d_bur;
            end
         endcase
         // Reset beats preset when both fire together
         if (ar_hit) begin
            s_nxt.q_out = '0;
            s_nxt.q_bur = '0;
         end else if (ap_hit) begin
            s_nxt.q_out = {N_IO{1'b1}};
            s_nxt.q_bur = {N_IO{1'b1}};
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         s_r.q_out <= '0;
         s_r.q_bur <= '0;
         s_r.por_cnt <= '0;
         s_r.por_busy <= `POR_BUSY_RST;
      end else if (i_ce) begin
         s_r <= s_nxt;
      end
   end

   assign o_por_busy = s_r.por_busy;

   // ----------------------------------------------------------------
   // Pin stage
   // ----------------------------------------------------------------
   pin_stage #(
      .N_IO(N_IO)
   ) u_pin_stage (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_mode(i_mode),
      .i_bank(i_bank),
      .i_cfg(i_cfg),
      .i_d_out(i_d_out),
      .i_q_out(s_r.q_out),
      .i_q_bur(s_r.q_bur),
      .o_pin_o(o_pin_o),
      .o_pin_oe_n(o_pin_oe_n)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_por_clear;
      @(posedge i_clock) disable iff (i_rst)
      s_r.por_busy |-> (s_r.q_out == '0) && (s_r.q_bur == '0);
   endproperty
   a_por_clear: assert property (p_por_clear)
      else $error("flip-flop not clear during power-up reset");

   property p_por_len;
      @(posedge i_clock) disable iff (i_rst)
      $fell(s_r.por_busy) |-> ($past(s_r.por_cnt) == CNT_W'(POR_CYCLES - 1));
   endproperty
   a_por_len: assert property (p_por_len)
      else $error("power-up reset ended at wrong count");

   property p_preload_out;
      @(posedge i_clock) disable iff (i_rst)
      (i_ce && !s_r.por_busy && i_mode == MODE_PRELOAD && i_bank == `BANK_OUT
         && !ar_hit && !ap_hit) |=> (s_r.q_out == $past(i_pin_i));
   endproperty
   a_preload_out: assert property (p_preload_out)
      else $error("output register preload lost");

   property p_preload_bur;
      @(posedge i_clock) disable iff (i_rst)
      (i_ce && !s_r.por_busy && i_mode == MODE_PRELOAD && i_bank == `BANK_BUR
         && !ar_hit && !ap_hit) |=> (s_r.q_bur == $past(i_pin_i)) && $stable(s_r.q_out);
   endproperty
   a_preload_bur: assert property (p_preload_bur)
      else $error("buried register preload lost");

   property p_async_reset;
      @(posedge i_clock) disable iff (i_rst)
      (i_ce && !s_r.por_busy && ar_hit) |=> (s_r.q_out == '0) && (s_r.q_bur == '0);
   endproperty
   a_async_reset: assert property (p_async_reset)
      else $error("reset from register did not clear");

   property p_async_preset;
      @(posedge i_clock) disable iff (i_rst)
      (i_ce && !s_r.por_busy && !ar_hit && ap_hit) |=>
         (s_r.q_out == {N_IO{1'b1}}) && (s_r.q_bur == {N_IO{1'b1}});
   endproperty
   a_async_preset: assert property (p_async_preset)
      else $error("preset from register did not set");

   property p_observe_hold;
      @(posedge i_clock) disable iff (i_rst)
      (i_ce && !s_r.por_busy && i_mode == MODE_OBSERVE && !ar_hit && !ap_hit) |=>
         $stable(s_r.q_out) && $stable(s_r.q_bur);
   endproperty
   a_observe_hold: assert property (p_observe_hold)
      else $error("observe disturbed register contents");

   property p_normal_load;
      @(posedge i_clock) disable iff (i_rst)
      (i_ce && !s_r.por_busy && i_mode == MODE_NORMAL && !ar_hit && !ap_hit) |=>
         (s_r.q_out == $past(i_d_out & ~comb_mask)) && (s_r.q_bur == $past(i_d_bur));
   endproperty
   a_normal_load: assert property (p_normal_load)
      else $error("normal mode did not clock functional data");

   // A low enable must hold every register, the power-up count included,
   // or the tester's cycle count and the device's would drift apart
   property p_ce_freeze;
      @(posedge i_clock) disable iff (i_rst)
      !i_ce |=> $stable(s_r);
   endproperty
   a_ce_freeze: assert property (p_ce_freeze)
      else $error("state moved while clock enable was low");

endmodule : macrocell_test_array

`default_nettype wire

// File: pin_tester_model.sv
// Tester model on the I/O pins: drives preload data, resolves pin levels
`default_nettype none

module pin_tester_model #(
   parameter int N_IO = 8
) (
   input wire logic i_clock,
   input wire logic [N_IO-1:0] i_drv,
   input wire logic [N_IO-1:0] i_drv_oe_n,
   input wire logic [N_IO-1:0] i_pin_o,
   input wire logic [N_IO-1:0] i_pin_oe_n,
   output logic [N_IO-1:0] o_pin_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [N_IO-1:0] last_r = '0;

   // Undriven pins flip each cycle so a stale value can never pass for data
   always_comb begin
      for (int i = 0; i < N_IO; i++) begin
         o_pin_level[i] = !i_pin_oe_n[i] ? i_pin_o[i] : (!i_drv_oe_n[i] ? i_drv[i] : ~last_r[i]);
      end
   end

   always_ff @(posedge i_clock) begin
      last_r <= o_pin_level;
   end
endmodule : pin_tester_model

`default_nettype wire

// File: register_preload_observe_reset_tb.sv
// Self-checking bench for the macrocell preload/observe test block
`default_nettype none

module register_preload_observe_reset_tb;
   import preload_observe_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int N = 8;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic i_ce = 1'b1;
   test_mode_type i_mode = MODE_NORMAL;
   logic i_bank = 1'b0;
   cell_cfg_type [N-1:0] i_cfg = '0;
   logic [N-1:0] i_d_out = '0;
   logic [N-1:0] i_d_bur = '0;
   logic i_ar_en = 1'b0;
   logic i_ap_en = 1'b0;
   logic [N-1:0] drv = '0;
   logic [N-1:0] drv_oe_n = '1;
   logic [N-1:0] pin_lvl;
   logic [N-1:0] o_pin_o;
   logic [N-1:0] o_pin_oe_n;
   logic o_por_busy;
   logic [31:0] seed = 32'h0000_9d1c;
   int err_count = 0;
   int checks_done = 0;

   always #5 i_clock = ~i_clock;

   macrocell_test_array #(.N_IO(N), .AR_CELL(0), .AP_CELL(1)) macrocell_test_array_i (
      .i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce), .i_mode(i_mode), .i_bank(i_bank),
      .i_cfg(i_cfg), .i_d_out(i_d_out), .i_d_bur(i_d_bur), .i_ar_en(i_ar_en),
      .i_ap_en(i_ap_en), .i_pin_i(pin_lvl), .o_pin_o(o_pin_o), .o_pin_oe_n(o_pin_oe_n),
      .o_por_busy(o_por_busy)
   );

   pin_tester_model #(.N_IO(N)) pin_tester_model_i (
      .i_clock(i_clock), .i_drv(drv), .i_drv_oe_n(drv_oe_n), .i_pin_o(o_pin_o),
      .i_pin_oe_n(o_pin_oe_n), .o_pin_level(pin_lvl)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : next_rand

   // One bit of every cell's configuration: 2 comb, 1 pol, 0 oe
   function automatic logic [N-1:0] field(input cell_cfg_type [N-1:0] c, input int b);
      logic [N-1:0] f;
      for (int i = 0; i < N; i++) begin
         f[i] = c[i][b];
      end
      return f;
   endfunction : field

   task automatic check(input logic [N-1:0] seen, input logic [N-1:0] exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   // Inputs change in the low half, setup is met before each rising edge
   task automatic cycle(input test_mode_type m, input logic b);
      i_mode = m;
      i_bank = b;
      drv_oe_n = (m == MODE_PRELOAD) ? '0 : '1;
      @(negedge i_clock);
   endtask : cycle

   // Two preload edges: the first may still see the pins driven by the device
   task automatic pre_obs(input logic b, input logic [N-1:0] v, input logic ob,
                          input logic [N-1:0] e1, input logic [N-1:0] e2,
                          input logic ar, input logic ap);
      drv = v;
      i_ar_en = 1'b0;
      i_ap_en = 1'b0;
      cycle(MODE_PRELOAD, b);
      cycle(MODE_PRELOAD, b);
      check(o_pin_oe_n, '1, "preload releases pins");
      i_ar_en = ar;
      i_ap_en = ap;
      cycle(MODE_OBSERVE, ob);
      check(o_pin_o, e1, "observed value");
      check(o_pin_oe_n, '0, "observe drives all pins");
      cycle(MODE_OBSERVE, ob);
      check(o_pin_o, e2, "observed after one more edge");
   endtask : pre_obs

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin : main
      logic [31:0] r;
      logic [N-1:0] v;
      logic [N-1:0] m;
      logic [N-1:0] qo;
      int n;
      repeat (5) @(negedge i_clock);
      check(N'(o_por_busy), 8'h01, "busy in reset");
      check(o_pin_oe_n, '1, "pins released in reset");
      check(o_pin_o, '0, "pins low in reset");
      r = next_rand();
      i_cfg = r[23:0] & 24'h6db6db;
      i_rst = 1'b0;
      for (n = 0; n < 1100 && o_por_busy === 1'b1; n++) begin
         if (n == 500) begin
            check(o_pin_o, field(i_cfg, 1), "cleared flops seen through polarity");
            drv = '1;
            cycle(MODE_PRELOAD, 1'b0);
         end else begin
            @(negedge i_clock);
         end
      end
      if (n >= 1100) begin
         err_count++;
         tally_and_finish();
      end
      check(N'(n == 1000), 8'h01, "power-up clear length");
      cycle(MODE_OBSERVE, 1'b0);
      check(o_pin_o, '0, "preload refused during power-up");
      cycle(MODE_OBSERVE, 1'b1);
      check(o_pin_o, '0, "buried cells cleared");
      pre_obs(1'b1, 8'hff, 1'b1, 8'hff, 8'hff, 1'b0, 1'b0);
      pre_obs(1'b0, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
      qo = '0;
      repeat (12) begin
         r = next_rand();
         i_cfg = r[23:0];
         i_d_bur = r[31:24];
         r = next_rand();
         v = r[N-1:0];
         pre_obs(r[8], v, r[8], v, v, 1'b0, 1'b0);
         if (r[8] == 1'b0) begin
            qo = v;
         end
         // A disabled edge in preload must neither release the pins nor load
         i_ce = 1'b0;
         cycle(MODE_PRELOAD, r[8]);
         check(o_pin_o, v, "pins frozen while disabled");
         check(o_pin_oe_n, '0, "drive frozen while disabled");
         i_ce = 1'b1;
         i_d_out = r[23:16];
         cycle(MODE_NORMAL, r[8]);
         m = field(i_cfg, 2);
         check(o_pin_o & m, (i_d_out ^ field(i_cfg, 1)) & m, "comb outputs restored");
         check(o_pin_o & ~m, (qo ^ field(i_cfg, 1)) & ~m, "registered outputs back");
         check(o_pin_oe_n, ~field(i_cfg, 0), "programmed enables back");
         // Combinatorial cells leave their register at zero in normal mode
         qo = i_d_out & ~m;
      end
      // Every cell combinatorial with live terms high: observe must show registers only
      i_cfg = {N{3'h4}};
      i_d_out = '1;
      pre_obs(1'b0, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
      i_cfg = '0;
      pre_obs(1'b0, 8'h81, 1'b0, 8'h81, 8'h00, 1'b1, 1'b0);
      cycle(MODE_OBSERVE, 1'b1);
      check(o_pin_o, '0, "reset line clears buried cells");
      pre_obs(1'b0, 8'h42, 1'b0, 8'h42, 8'hff, 1'b0, 1'b1);
      tally_and_finish();
   end
endmodule : register_preload_observe_reset_tb

`default_nettype wire
